// [core/tgl_regs.svh]
// register map, field positions, reset values and constants for the tone and loop-back bank
// Contract
// [RULE1] The upper seven bits of the first control register hold the tone level, zero is off.
// [RULE2] Nonzero level codes step from -12.1 dBm0 by 0.1 dBm0 up to +0.5 dBm0 at all ones.
// [RULE3] Software forms the level code as ten times the wanted level plus 122.
// [RULE4] With ring mode clear, a 9-bit frequency uses bit 0 of reg one and all of reg two.
// [RULE5] In tone mode the frequency code is the frequency divided by ten, 300 to 3400 Hz.
// [RULE6] Software keeps tone-mode frequency codes inside the 300 to 3400 Hz band.
// [RULE7] With ring mode set, the three upper frequency bits are ignored.
// [RULE8] In ring mode the low six bits are the ring frequency in hertz, 15 to 50 Hz.
// [RULE9] Channel 2 loop select in bits 7:6: 00 and 01 off, 10 digital, 11 analog.
// [RULE10] Channel 2 digital loop routes transmit data to receive, ignores serial input.
// [RULE11] Channel 2 analog loop feeds receive output to transmit, ignores analog inputs.
// [RULE12] The system derives both frame syncs from one clock source during loop-back.
// [RULE13] Channel 1 loop select sits in bits 5:4, codes 00 and 01 turn it off.
// [RULE14] Channel 1 code 10 is digital loop-back and code 11 is analog loop-back.
// [RULE15] Software writes zeros to the four low factory bits of the loop-back register.
// [RULE16] The ring mode bit is an input and switches the frequency meaning at once.
// [RULE17] All three registers reset to zero: tone off and loop-back off.
`ifndef TGL_REGS_SVH
`define TGL_REGS_SVH
`define TGL_OFS_LVL 8'h00
`define TGL_OFS_FLO 8'h04
`define TGL_OFS_LOOP 8'h08
`define TGL_RST_LVL 8'h00
`define TGL_RST_FLO 8'h00
`define TGL_RST_LOOP 8'h00
`define TGL_LVL_MSB 7
`define TGL_LVL_LSB 1
`define TGL_FHI_BIT 0
`define TGL_CH2_LOOP_HI 7
`define TGL_CH1_LOOP_HI 5
`define TGL_LVL_BIAS 8'h7A
`define TGL_FREQ_STEP 13'h000A
`define TGL_RESP_OKAY 2'h0
`define TGL_RESP_SLVERR 2'h2
`endif

// [core/tgl_pkg.sv]
// types shared by the tone and loop-back control bank
package tgl_pkg;
   typedef enum logic [1:0] {LOOP_OFF, LOOP_DIG, LOOP_ANA} tgl_loop_type;
   typedef enum logic {RD_IDLE, RD_RESP} tgl_rd_type;
endpackage

// [core/tgl_ctrl.sv]
// tone generator 1 and loop-back control registers behind an axi4-lite slave
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`include "tgl_regs.svh"

module tgl_ctrl
   import tgl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // ring mode bit from the channel 2 control register
   input wire logic ring_mode_select,
   // tone generator controls
   output logic [6:0] tone_level,
   output logic tone_on,
   output logic signed [7:0] tone_level_tenth_db,
   output logic [8:0] tone_freq_code,
   output logic [12:0] tone_freq_hz,
   // serial audio paths, index 0 is channel 1
   input wire logic [1:0] tx_pcm_bit,
   input wire logic serial_audio_in,
   output logic [1:0] serial_audio_out,
   output logic [1:0] rx_pcm_bit,
   // loop-back state per channel
   output logic [1:0] dig_loop,
   output logic [1:0] ana_loop
);

   logic [7:0] lvl_r;
   logic [7:0] flo_r;
   logic [7:0] loop_r;
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] wr_addr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   tgl_rd_type rd_state_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic do_wr;
   logic wr_hit;
   logic [1:0] rx_pcm_r;
   logic [1:0] sao_r;

   // both halves are held before a write lands, so either arrival order works
   assign do_wr = aw_held_r && w_held_r && !bvalid_r;
   assign wr_hit = (wr_addr_r == `TGL_OFS_LVL) || (wr_addr_r == `TGL_OFS_FLO) ||
                   (wr_addr_r == `TGL_OFS_LOOP);

   // handshake outputs
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = (rd_state_r == RD_IDLE);
   assign s_axi_rvalid = (rd_state_r == RD_RESP);
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // write address capture
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aw_held_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_r <= 1'b1;
         wr_addr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      else if (do_wr)
         aw_held_r <= 1'b0;
   end

   // write data capture
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         w_held_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end
      else if (do_wr)
         w_held_r <= 1'b0;
   end

   // write response, unmapped offsets answer slverr
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= `TGL_RESP_OKAY;
      end
      else if (do_wr)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? `TGL_RESP_OKAY : `TGL_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   // register file; only lane 0 carries data, upper lanes are dropped
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lvl_r <= `TGL_RST_LVL; // RULE17
         flo_r <= `TGL_RST_FLO;
         loop_r <= `TGL_RST_LOOP;
      end
      else if (do_wr && wstrb_r[0])
      begin
         if (wr_addr_r == `TGL_OFS_LVL)
            lvl_r <= wdata_r[7:0]; // RULE1
         if (wr_addr_r == `TGL_OFS_FLO)
            flo_r <= wdata_r[7:0]; // RULE4
         // factory bits are stored as written; software keeps them zero
         if (wr_addr_r == `TGL_OFS_LOOP)
            loop_r <= wdata_r[7:0]; // RULE15
      end
   end

   // read channel, one wait state, data held until rready
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_state_r <= RD_IDLE;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `TGL_RESP_OKAY;
      end
      else
      begin
         case (rd_state_r)
            RD_IDLE:
               if (s_axi_arvalid)
               begin
                  rd_state_r <= RD_RESP;
                  rresp_r <= `TGL_RESP_OKAY;
                  case ({s_axi_araddr[7:2], 2'h0})
                     `TGL_OFS_LVL: rdata_r <= {24'h00_0000, lvl_r};
                     `TGL_OFS_FLO: rdata_r <= {24'h00_0000, flo_r};
                     `TGL_OFS_LOOP: rdata_r <= {24'h00_0000, loop_r};
                     default:
                     begin
                        rdata_r <= 32'h0000_0000;
                        rresp_r <= `TGL_RESP_SLVERR;
                     end
                  endcase
               end
            RD_RESP:
               if (s_axi_rready)
                  rd_state_r <= RD_IDLE;
            default: rd_state_r <= RD_IDLE;
         endcase
      end
   end

   // level decode: tenths of dbm0, the level code less the 0x7A bias
   assign tone_level = lvl_r[`TGL_LVL_MSB:`TGL_LVL_LSB]; // RULE1
   assign tone_on = (tone_level != 7'h00); // RULE1
   assign tone_level_tenth_db = $signed({1'b0, tone_level}) - $signed(`TGL_LVL_BIAS); // RULE2

   // combinational so a ring mode change takes effect without a cycle of lag
   always_comb
   begin
      if (ring_mode_select) // RULE16
      begin
         tone_freq_code = {3'h0, flo_r[5:0]}; // RULE7
         tone_freq_hz = {7'h00, flo_r[5:0]}; // RULE8
      end
      else
      begin
         tone_freq_code = {lvl_r[`TGL_FHI_BIT], flo_r}; // RULE4
         tone_freq_hz = 13'({4'h0, tone_freq_code} * `TGL_FREQ_STEP); // RULE5
      end
   end

   // loop mode decode; 00 and 01 both mean off
   function automatic tgl_loop_type tgl_loop_dec(input logic [1:0] sel);
      tgl_loop_dec = !sel[1] ? LOOP_OFF : (sel[0] ? LOOP_ANA : LOOP_DIG);
   endfunction

   // per-channel loop decode and serial path; channel 1 is index 0
   genvar gc;
   generate
      for (gc = 0; gc < 2; gc++)
      begin : g_ch
         tgl_loop_type mode;
         assign mode = tgl_loop_dec(loop_r[`TGL_CH1_LOOP_HI + 2 * gc -: 2]); // RULE9 RULE13
         assign dig_loop[gc] = (mode == LOOP_DIG); // RULE9 RULE14
         // analog muxes sit outside; this level ignores the analog inputs
         assign ana_loop[gc] = (mode == LOOP_ANA); // RULE11 RULE14
         // digital loop takes this channel's own transmit data, input pin ignored
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               rx_pcm_r[gc] <= 1'b0;
            else
               rx_pcm_r[gc] <= dig_loop[gc] ? tx_pcm_bit[gc] : serial_audio_in; // RULE10
         end
         // transmit output keeps running in every loop mode
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               sao_r[gc] <= 1'b0;
            else
               sao_r[gc] <= tx_pcm_bit[gc]; // RULE10
         end
      end
   endgenerate

   assign rx_pcm_bit = rx_pcm_r;
   assign serial_audio_out = sao_r;

   // checks on the decoded controls
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_wr_lvl;
      do_wr && wstrb_r[0] && (wr_addr_r == `TGL_OFS_LVL);
   endsequence

   sequence s_wr_loop;
      do_wr && wstrb_r[0] && (wr_addr_r == `TGL_OFS_LOOP);
   endsequence

   a_level_write: assert property (s_wr_lvl |=> // RULE1
      (tone_level == $past(wdata_r[7:1])) && (tone_on == ($past(wdata_r[7:1]) != 7'h00)))
      else $error("level field or off decode wrong after write");

   a_level_ends: assert property ( // RULE2
      ((tone_level == 7'h01) |-> (tone_level_tenth_db == -8'sh79)) and
      ((tone_level == 7'h7F) |-> (tone_level_tenth_db == 8'sh05)))
      else $error("level end points wrong");

   a_tone_freq: assert property (!ring_mode_select |-> // RULE4
      (tone_freq_code[8] == lvl_r[0]) && (tone_freq_code[7:0] == flo_r))
      else $error("tone frequency field not taken from both registers");

   a_tone_hz: assert property ((!ring_mode_select && tone_freq_code == 9'h096) |-> // RULE5
      (tone_freq_hz == 13'h05DC))
      else $error("tone code 150 not 1500 hz");

   a_ring_mask: assert property (ring_mode_select |-> // RULE7
      (tone_freq_code[8:6] == 3'h0) && (tone_freq_code[5:0] == flo_r[5:0]))
      else $error("upper frequency bits leak in ring mode");

   a_ring_hz: assert property (ring_mode_select |-> (tone_freq_hz == {7'h00, flo_r[5:0]})) // RULE8
      else $error("ring frequency not in hertz");

   a_ch2_loop: assert property (s_wr_loop |=> // RULE9
      (dig_loop[1] == ($past(wdata_r[7:6]) == 2'h2)) &&
      (ana_loop[1] == ($past(wdata_r[7:6]) == 2'h3)))
      else $error("channel 2 loop decode wrong");

   a_dig_route: assert property (dig_loop[1] |=> (rx_pcm_bit[1] == $past(tx_pcm_bit[1])) && // RULE10
      (serial_audio_out[1] == $past(tx_pcm_bit[1])))
      else $error("channel 2 digital loop not routed");

   a_ana_only: assert property (ana_loop[1] |-> !dig_loop[1] && loop_r[7:6] == 2'h3) // RULE11
      else $error("channel 2 analog loop decode wrong");

   a_ch1_loop: assert property ((!loop_r[5] |-> !dig_loop[0] && !ana_loop[0]) and // RULE13
      (loop_r[5:4] == 2'h2 |=> rx_pcm_bit[0] == $past(tx_pcm_bit[0]))) // RULE14
      else $error("channel 1 loop decode wrong");

   a_ring_switch: assert property ($rose(ring_mode_select) |-> // RULE16
      (tone_freq_code[8:6] == 3'h0) && (tone_freq_hz[12:6] == 7'h00))
      else $error("ring switch not immediate");

   a_reset_zero: assert property ($past(!reset_n) |-> // RULE17
      !tone_on && (dig_loop == 2'h0) && (ana_loop == 2'h0) && (loop_r == 8'h00))
      else $error("registers not zero after reset");

   a_bresp_next: assert property ((aw_held_r && w_held_r && !bvalid_r) |=> s_axi_bvalid)
      else $error("write response late");

   // no write, no change: fields only move on a landed lane 0 write
   a_level_hold: assert property ( // RULE1
      !(do_wr && wstrb_r[0] && (wr_addr_r == `TGL_OFS_LVL)) |=> $stable(lvl_r))
      else $error("level register changed without a write");

   a_freq_hold: assert property ( // RULE4
      !(do_wr && wstrb_r[0] && (wr_addr_r == `TGL_OFS_FLO)) |=> $stable(flo_r))
      else $error("frequency register changed without a write");

   a_loop_hold: assert property ( // RULE9
      !(do_wr && wstrb_r[0] && (wr_addr_r == `TGL_OFS_LOOP)) |=> $stable(loop_r))
      else $error("loop register changed without a write");

   a_level_mid: assert property ((tone_level == 7'h40) |-> // RULE2
      (tone_level_tenth_db == -8'sh3A))
      else $error("level code 64 not at -5.8 dbm0");

   a_tone_top: assert property ((!ring_mode_select && (tone_freq_code == 9'h154)) |-> // RULE5
      (tone_freq_hz == 13'h0D48))
      else $error("top tone code not at 3400 hz");

   a_ch1_decode: assert property (s_wr_loop |=> // RULE14
      (dig_loop[0] == ($past(wdata_r[5:4]) == 2'h2)) &&
      (ana_loop[0] == ($past(wdata_r[5:4]) == 2'h3)))
      else $error("channel 1 loop decode wrong");

   // reset_n in the antecedent skips the edge at which the serial flops leave reset
   a_pin_path: assert property ((reset_n && !dig_loop[1]) |=> // RULE9
      (rx_pcm_bit[1] == $past(serial_audio_in)))
      else $error("channel 2 receive not taken from the input pin");

   a_out_follow: assert property (reset_n |=> // RULE10
      (serial_audio_out == $past(tx_pcm_bit)))
      else $error("serial output stopped following transmit data");

   a_rd_next: assert property ((s_axi_arvalid && s_axi_arready) |=>
      s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");

   a_rd_unmapped: assert property (
      (s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:2] > 6'h02)) |=>
      (s_axi_rresp == `TGL_RESP_SLVERR) && (s_axi_rdata == 32'h0000_0000))
      else $error("unmapped read not refused");

endmodule

// [test/test_tone_gen1_and_loopback_ctrl.sv]
// self-checking bench for the tone level, tone frequency and loop-back register bank
`include "tgl_regs.svh"

module test_tone_gen1_and_loopback_ctrl
   import tgl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic ring_mode_select = 1'b0;
   logic [6:0] tone_level;
   logic tone_on;
   logic signed [7:0] tone_level_tenth_db;
   logic [8:0] tone_freq_code;
   logic [12:0] tone_freq_hz;
   logic [1:0] tx_pcm_bit = 2'h0;
   logic serial_audio_in = 1'b0;
   logic [1:0] serial_audio_out, rx_pcm_bit, dig_loop, ana_loop;
   int num_errors = 0;
   int num_checks = 0;

   tgl_ctrl i_dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .ring_mode_select(ring_mode_select), .tone_level(tone_level),
      .tone_on(tone_on), .tone_level_tenth_db(tone_level_tenth_db),
      .tone_freq_code(tone_freq_code), .tone_freq_hz(tone_freq_hz), .tx_pcm_bit(tx_pcm_bit),
      .serial_audio_in(serial_audio_in), .serial_audio_out(serial_audio_out),
      .rx_pcm_bit(rx_pcm_bit), .dig_loop(dig_loop), .ana_loop(ana_loop));

   // 10 MHz clock
   always #50 clk = ~clk;

   // one comparison, counted; unknowns never match
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // address and data offered together, each dropped once taken, response waited for
   task wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // single read, rready held until rvalid is seen
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // every register reads zero after reset, tone and loops off
   task test_reset();
      logic [31:0] d;
      logic [1:0] r;
      rd(`TGL_OFS_LVL, d, r);
      chk(d, 32'h0);
      rd(`TGL_OFS_FLO, d, r);
      chk(d, 32'h0);
      rd(`TGL_OFS_LOOP, d, r);
      chk(d, 32'h0);
      chk({31'h0, tone_on}, 32'h0);
      chk({28'h0, dig_loop, ana_loop}, 32'h0);
   endtask

   // level codes at both ends, the worked -5.8 example and off
   task test_level();
      logic [7:0] lv[4] = '{8'h01, 8'h40, 8'h7F, 8'h00};
      logic [1:0] r;
      foreach (lv[i])
      begin
         wr(`TGL_OFS_LVL, {lv[i][6:0], 1'b0}, r);
         chk({25'h0, tone_level}, {24'h0, lv[i]});
         chk({31'h0, tone_on}, {31'h0, lv[i] != 8'h00});
         if (lv[i] != 8'h00)
            chk({24'h0, tone_level_tenth_db}, {24'h0, lv[i] - 8'h7A});
      end
   endtask

   // one frequency setting in tone or ring mode; ring is flipped without a write
   task freq_case(input logic fhi, input logic [7:0] flo, input logic ring,
                  input logic [8:0] code, input logic [12:0] hz);
      logic [1:0] r;
      wr(`TGL_OFS_LVL, {7'h01, fhi}, r);
      wr(`TGL_OFS_FLO, flo, r);
      ring_mode_select <= ring;
      @(posedge clk);
      chk({23'h0, tone_freq_code}, {23'h0, code});
      chk({19'h0, tone_freq_hz}, {19'h0, hz});
   endtask

   // every loop code on both channels, with serial routing in both data polarities
   task test_loop();
      logic [1:0] r;
      logic [31:0] d;
      logic [1:0] c2, c1, ed, ea;
      for (int c = 0; c < 4; c++)
      begin
         c2 = 2'(c);
         c1 = 2'(3 - c);
         wr(`TGL_OFS_LOOP, {c2, c1, 4'h0}, r);
         rd(`TGL_OFS_LOOP, d, r);
         chk(d, {24'h0, c2, c1, 4'h0});
         ed = {c2 == 2'h2, c1 == 2'h2};
         ea = {c2 == 2'h3, c1 == 2'h3};
         chk({30'h0, dig_loop}, {30'h0, ed});
         chk({30'h0, ana_loop}, {30'h0, ea});
         for (int p = 0; p < 2; p++)
         begin
            tx_pcm_bit <= p[0] ? 2'h3 : 2'h0;
            serial_audio_in <= ~p[0];
            repeat (2) @(posedge clk);
            chk({30'h0, serial_audio_out}, {30'h0, {2{p[0]}}});
            chk({30'h0, rx_pcm_bit}, {30'h0, (ed & {2{p[0]}}) | (~ed & {2{~p[0]}})});
         end
      end
   endtask

   // unmapped place answers with an error and leaves the loop register untouched
   task test_unmapped();
      logic [1:0] r;
      logic [31:0] d;
      wr(8'h0C, 8'hFF, r);
      chk({30'h0, r}, {30'h0, `TGL_RESP_SLVERR});
      rd(8'h0C, d, r);
      chk({d[29:0], r}, {30'h0, `TGL_RESP_SLVERR});
      rd(`TGL_OFS_LOOP, d, r);
      chk(d, 32'h0);
   endtask

   // a reset in mid-run clears a bank that holds tone and loop settings
   task test_mid_reset();
      logic [1:0] r;
      wr(`TGL_OFS_LVL, 8'h81, r);
      wr(`TGL_OFS_LOOP, 8'hA0, r);
      chk({30'h0, dig_loop}, 32'h3);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      test_reset();
      chk({23'h0, tone_freq_code}, 32'h0);
   endtask

   task finish_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      test_reset();
      test_level();
      freq_case(1'b1, 8'h54, 1'b0, 9'h154, 13'h0D48);
      freq_case(1'b0, 8'h1E, 1'b0, 9'h01E, 13'h012C);
      freq_case(1'b0, 8'h96, 1'b0, 9'h096, 13'h05DC);
      freq_case(1'b1, 8'hD4, 1'b1, 9'h014, 13'h0014);
      freq_case(1'b1, 8'hCF, 1'b1, 9'h00F, 13'h000F);
      freq_case(1'b0, 8'h32, 1'b0, 9'h032, 13'h01F4);
      test_loop();
      test_mid_reset();
      test_unmapped();
      finish_test();
   end

   // watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      #2000000;
      num_errors++;
      finish_test();
   end
endmodule
